// ### logic/adc_host_pkg.sv
// Package: constants and types for the converter host controller
package adc_host_pkg;
   // ****************************************
   // Register map (AXI4-Lite byte addresses)
   // ****************************************
   localparam logic [7:0] CTRL_OFS   = 8'h00;
   localparam logic [7:0] CONFIG_OFS = 8'h04;
   localparam logic [7:0] STATUS_OFS = 8'h08;
   localparam logic [7:0] RESULT_OFS = 8'h0c;
   localparam logic [7:0] ENTRY_OFS  = 8'h10;
   // ****************************************
   // Command codes in CTRL[2:0]
   // ****************************************
   localparam logic [2:0] CMD_CONVERT = 3'h1;
   localparam logic [2:0] CMD_WRITE   = 3'h2;
   localparam logic [2:0] CMD_READBK  = 3'h3;
   localparam logic [2:0] CMD_READ    = 3'h4;
   localparam int CTRL_PD_BIT   = 8;
   localparam int CTRL_CSPD_BIT = 9;
   localparam int CTRL_MODE1_BIT = 10;
   localparam int CTRL_MODE0_BIT = 11;
   // ****************************************
   // Entry / config field positions
   // ****************************************
   localparam int ENT_LAST = 0;
   localparam int ENT_GAIN = 1;
   localparam int ENT_POL  = 2;
   localparam int ENT_CH_LO = 3;
   localparam int ENT_PAIR = 6;
   localparam int ENT_W    = 7;
   localparam int RES_W    = 12;
   // ****************************************
   // Timing, 50 MHz clock
   // ****************************************
   localparam int CLK_NS        = 20;
   localparam int STROBE_LOW_NS = 50;
   localparam int STROBE_HI_NS  = 50;
   localparam int TRIG_HI_NS    = 400;
   localparam logic [4:0] STROBE_LOW_CYC = 5'((STROBE_LOW_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [4:0] STROBE_HI_CYC  = 5'((STROBE_HI_NS + CLK_NS - 1) / CLK_NS);
   // Timer holds a strobe one cycle past its count, so the trigger loads one less
   localparam logic [4:0] TRIG_HI_CYC    = 5'(TRIG_HI_NS / CLK_NS - 1);
   localparam logic [4:0] SETUP_CYC      = 5'h02;
   typedef enum logic [1:0] {AXI_OKAY = 2'b00, AXI_SLVERR = 2'b10} resp_t;
endpackage : adc_host_pkg

// ### logic/strobe_timer.sv
// Down counter giving one-cycle done pulse after a loaded count
`timescale 1ns/1ns
module strobe_timer
   import adc_host_pkg::*;
(
   input  wire logic       core_clk_in,
   input  wire logic       rst_n_in,
   input  wire logic       load_in,
   input  wire logic [4:0] count_in,
   output logic            done_out
);
   logic [4:0] cnt_r;
   logic       run_r;
   always_ff @(posedge core_clk_in)
   begin
      if (!rst_n_in)
      begin
         cnt_r    <= 5'h00;
         run_r    <= 1'b0;
         done_out <= 1'b0;
      end
      else if (load_in)
      begin
         cnt_r    <= count_in;
         run_r    <= 1'b1;
         done_out <= 1'b0;
      end
      else
      begin
         done_out <= run_r && (cnt_r <= 5'h01);
         if (cnt_r <= 5'h01)
            run_r <= 1'b0;
         else
            cnt_r <= cnt_r - 5'h01;
      end
   end
endmodule : strobe_timer

// ### logic/adc_host_ctrl.sv
// Host controller driving the sampling converter pins, commanded over AXI4-Lite
//
// The AXI4-Lite register port and the placing of the registers were decided locally.
`timescale 1ns/1ns
module adc_host_ctrl
   import adc_host_pkg::*;
(
   input  wire logic        core_clk_in,
   input  wire logic        rst_n_in,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   output logic             chip_select_n_out,
   output logic             write_n_out,
   output logic             read_n_out,
   output logic             convert_trigger_n_out,
   output logic             power_down_n_out,
   output logic             mode_pin_zero_out,
   output logic             mode_pin_one_out,
   output logic [2:0]       channel_select_out,
   output logic             pair_select_out,
   output logic             gain_select_out,
   output logic             polarity_select_out,
   input  wire logic [11:0] result_line_in,
   input  wire logic [2:0]  channel_echo_in,
   input  wire logic        pair_flag_in,
   input  wire logic        busy_in
);
   typedef enum {ST_IDLE, ST_SETUP, ST_LOW, ST_HIGH, ST_WAITBUSY} state_t;
   state_t      state_r;
   logic [2:0]  cmd_r;
   logic [15:0] result_r;
   logic [6:0]  entry_r;
   logic        done_r;
   logic [31:0] wdata_r;
   logic [7:0]  awaddr_r;
   logic        aw_have_r;
   logic        w_have_r;
   logic        busy_d_r;
   logic        tmr_load;
   logic [4:0]  tmr_count;
   logic        tmr_done;

   // ****************************************
   // Bus slave decode
   // ****************************************
   wire wr_go      = aw_have_r && w_have_r && !s_axi_bvalid;
   wire wr_ctrl    = wr_go && (awaddr_r == CTRL_OFS) && s_axi_wstrb[0];
   wire wr_config  = wr_go && (awaddr_r == CONFIG_OFS) && s_axi_wstrb[0];
   wire wr_known   = (awaddr_r == CTRL_OFS) || (awaddr_r == CONFIG_OFS);
   wire [2:0] new_cmd = wdata_r[2:0];
   wire start_cmd  = wr_ctrl && (state_r == ST_IDLE) && (new_cmd != 3'h0);
   wire nap_sel    = wdata_r[CTRL_CSPD_BIT] && wdata_r[CTRL_PD_BIT];
   wire rd_go      = s_axi_arvalid && s_axi_arready;
   wire busy_rise  = busy_in && !busy_d_r;
   wire [31:0] status_word = {27'h0, busy_in, done_r, state_r != ST_IDLE,
                              !mode_pin_zero_out && mode_pin_one_out, 1'b0};
   wire [31:0] rd_mux = (s_axi_araddr == CTRL_OFS)   ? {20'h0, mode_pin_zero_out,
                        mode_pin_one_out, !chip_select_n_out, !power_down_n_out,
                        5'h0, cmd_r} :
                        (s_axi_araddr == CONFIG_OFS) ? {25'h0, pair_select_out,
                        channel_select_out, polarity_select_out, gain_select_out, 1'b0} :
                        (s_axi_araddr == STATUS_OFS) ? status_word :
                        (s_axi_araddr == RESULT_OFS) ? {16'h0, result_r} :
                        (s_axi_araddr == ENTRY_OFS)  ? {25'h0, entry_r} : 32'h0;
   wire rd_known = (s_axi_araddr <= ENTRY_OFS) && (s_axi_araddr[1:0] == 2'b00);

   always_ff @(posedge core_clk_in)
   begin
      if (!rst_n_in)
      begin
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         aw_have_r     <= 1'b0;
         w_have_r      <= 1'b0;
         awaddr_r      <= 8'h00;
         wdata_r       <= 32'h0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= AXI_OKAY;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            awaddr_r      <= s_axi_awaddr;
            aw_have_r     <= 1'b1;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            wdata_r      <= s_axi_wdata;
            w_have_r     <= 1'b1;
            s_axi_wready <= 1'b0;
         end
         if (wr_go)
         begin
            aw_have_r    <= 1'b0;
            w_have_r     <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_known ? AXI_OKAY : AXI_SLVERR;
         end
         if (s_axi_bvalid && s_axi_bready)
         begin
            s_axi_bvalid  <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
         end
      end
   end

   always_ff @(posedge core_clk_in)
   begin
      if (!rst_n_in)
      begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0;
         s_axi_rresp   <= AXI_OKAY;
      end
      else if (rd_go)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rdata   <= rd_mux;
         s_axi_rresp   <= rd_known ? AXI_OKAY : AXI_SLVERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
         s_axi_rvalid  <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   // ****************************************
   // Static pins: config, mode, power-down
   // ****************************************
   always_ff @(posedge core_clk_in)
   begin
      if (!rst_n_in)
      begin
         pair_select_out     <= 1'b0;
         channel_select_out  <= 3'h0;
         polarity_select_out <= 1'b0;
         gain_select_out     <= 1'b1;
         mode_pin_zero_out   <= 1'b1;
         mode_pin_one_out    <= 1'b0;
         power_down_n_out    <= 1'b1;
      end
      else
      begin
         // Values change only while idle so write setup stays honest
         if (wr_config && state_r == ST_IDLE)
         begin
            pair_select_out     <= wdata_r[ENT_PAIR];
            channel_select_out  <= wdata_r[ENT_CH_LO +: 3];
            polarity_select_out <= wdata_r[ENT_POL];
            gain_select_out     <= wdata_r[ENT_GAIN];
         end
         if (wr_ctrl && state_r == ST_IDLE)
         begin
            // Mode pins encoded as the device expects; counter restarts on entry
            mode_pin_one_out  <= wdata_r[CTRL_MODE1_BIT];
            mode_pin_zero_out <= wdata_r[CTRL_MODE0_BIT];
            power_down_n_out  <= !wdata_r[CTRL_PD_BIT];
         end
      end
   end

   // ****************************************
   // Strobe sequencer
   // ****************************************
   wire is_rd_cmd = (cmd_r == CMD_READ) || (cmd_r == CMD_READBK);
   assign tmr_load  = start_cmd || (tmr_done && (state_r == ST_SETUP || state_r == ST_LOW));
   assign tmr_count = start_cmd ? SETUP_CYC :
                      (state_r == ST_SETUP && cmd_r == CMD_CONVERT) ? TRIG_HI_CYC :
                      (state_r == ST_SETUP) ? STROBE_LOW_CYC : STROBE_HI_CYC;

   strobe_timer u_timer
   (
      .core_clk_in (core_clk_in),
      .rst_n_in    (rst_n_in),
      .load_in     (tmr_load),
      .count_in    (tmr_count),
      .done_out    (tmr_done)
   );

   always_ff @(posedge core_clk_in)
   begin
      if (!rst_n_in)
      begin
         state_r               <= ST_IDLE;
         cmd_r                 <= 3'h0;
         chip_select_n_out     <= 1'b1;
         write_n_out           <= 1'b1;
         read_n_out            <= 1'b1;
         convert_trigger_n_out <= 1'b1;
         result_r              <= 16'h0;
         entry_r               <= 7'h0;
         done_r                <= 1'b0;
         busy_d_r              <= 1'b1;
      end
      else
      begin
         busy_d_r <= busy_in;
         if (rd_go && s_axi_araddr == STATUS_OFS)
            done_r <= 1'b0;
         case (state_r)
            ST_IDLE:
            begin
               if (start_cmd)
               begin
                  cmd_r   <= new_cmd;
                  state_r <= ST_SETUP;
                  // Select also chooses nap over sleep during power-down
                  chip_select_n_out <= !(wdata_r[CTRL_CSPD_BIT] || new_cmd != CMD_WRITE);
               end
               else if (wr_ctrl)
               begin
                  // Select level picks nap (low) or sleep (high) while powered down
                  chip_select_n_out <= !nap_sel;
               end
            end
            ST_SETUP:
            begin
               if (tmr_done)
               begin
                  state_r <= ST_LOW;
                  if (cmd_r == CMD_CONVERT)
                     convert_trigger_n_out <= 1'b0;
                  else if (cmd_r == CMD_WRITE)
                     write_n_out <= 1'b0;
                  else
                     read_n_out <= 1'b0;
               end
            end
            ST_LOW:
            begin
               if (tmr_done)
               begin
                  if (is_rd_cmd)
                  begin
                     // Sample before lifting read: bus floats once read is high
                     result_r <= {pair_flag_in, channel_echo_in, result_line_in};
                     entry_r  <= {pair_flag_in, channel_echo_in,
                                  result_line_in[RES_W-1 -: 3]};
                  end
                  convert_trigger_n_out <= 1'b1;
                  write_n_out           <= 1'b1;
                  read_n_out            <= 1'b1;
                  state_r <= (cmd_r == CMD_CONVERT) ? ST_WAITBUSY : ST_HIGH;
               end
            end
            ST_HIGH:
            begin
               if (tmr_done)
               begin
                  chip_select_n_out <= 1'b1;
                  done_r            <= 1'b1;
                  state_r           <= ST_IDLE;
               end
            end
            ST_WAITBUSY:
            begin
               if (busy_rise)
               begin
                  chip_select_n_out <= 1'b1;
                  done_r            <= 1'b1;
                  state_r           <= ST_IDLE;
               end
            end
            default: state_r <= ST_IDLE;
         endcase
      end
   end
endmodule : adc_host_ctrl

// ### verif/adc_host_props.sv
// Checker on the controller pin and bus timing
`timescale 1ns/1ns
module adc_host_props
(
   input  wire logic        core_clk_in,
   input  wire logic        rst_n_in,
   input  wire logic        s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic        s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic [31:0] s_axi_rdata,
   input  wire logic        chip_select_n_out,
   input  wire logic        write_n_out,
   input  wire logic        read_n_out,
   input  wire logic        convert_trigger_n_out
);
   // ***
   // Properties
   // ***
   default clocking cb @(posedge core_clk_in);
   endclocking
   default disable iff (!rst_n_in);
   property p_cv_cs;
      $fell(convert_trigger_n_out) |-> !chip_select_n_out;
   endproperty
   a_cv_cs: assert property (p_cv_cs) else $error("trigger without select");
   property p_rd_cs;
      $fell(read_n_out) |-> !chip_select_n_out;
   endproperty
   a_rd_cs: assert property (p_rd_cs) else $error("read without select");
   property p_setup;
      $fell(chip_select_n_out) |-> (read_n_out && convert_trigger_n_out && write_n_out)[*2];
   endproperty
   a_setup: assert property (p_setup) else $error("strobe too soon after select");
   property p_trig;
      $fell(convert_trigger_n_out) |-> ##[1:20] convert_trigger_n_out;
   endproperty
   a_trig: assert property (p_trig) else $error("trigger held low too long");
   property p_wr_low;
      $fell(write_n_out) |-> !write_n_out [*3];
   endproperty
   a_wr_low: assert property (p_wr_low) else $error("write strobe too short");
   property p_rd_low;
      $fell(read_n_out) |-> !read_n_out [*3];
   endproperty
   a_rd_low: assert property (p_rd_low) else $error("read strobe too short");
   property p_bstand;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
   endproperty
   a_bstand: assert property (p_bstand) else $error("write answer dropped");
   property p_rstand;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   a_rstand: assert property (p_rstand) else $error("read answer dropped");
endmodule : adc_host_props
bind adc_host_ctrl adc_host_props u_props (.core_clk_in, .rst_n_in, .s_axi_bvalid,
   .s_axi_bready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .chip_select_n_out,
   .write_n_out, .read_n_out, .convert_trigger_n_out);

// ### verif/adc_dev_model.sv
// Behavioural model of the converter on the controller's pins
`timescale 1ns/1ns
module adc_dev_model
#(parameter int CONV_NS = 1000)
(
   input  wire logic        cs_n_in,
   input  wire logic        wr_n_in,
   input  wire logic        rd_n_in,
   input  wire logic        cv_n_in,
   input  wire logic        pd_n_in,
   input  wire logic        mode_zero_in,
   input  wire logic        mode_one_in,
   input  wire logic [2:0]  ch_in,
   input  wire logic        pair_in,
   input  wire logic        gain_in,
   input  wire logic        pol_in,
   output logic      [11:0] result_line_out,
   output logic      [2:0]  channel_echo_out,
   output logic             pair_flag_out,
   output logic             busy_out
);
   // ***
   // Sequence memory, conversion and bus
   // ***
   logic [6:0]  mem_r [16];
   logic [3:0]  loc_r = 4'h0;
   logic [5:0]  cfg_r = 6'h00;
   logic [5:0]  cap;
   logic [15:0] res_r = 16'h0000;
   logic        conv_r = 1'b0;
   wire         prog = mode_one_in && !mode_zero_in;
   // Analog pairing and the shared input are not modelled; the pair bit is only echoed
   wire  [5:0]  pins = {pair_in, ch_in, pol_in, gain_in};
   wire  [15:0] drv = prog ? {mem_r[loc_r], 9'h000} : res_r;
   wire         en = !rd_n_in && !cs_n_in;
   // Released lines show the inverse so a stale sample cannot pass
   assign {pair_flag_out, channel_echo_out, result_line_out} = en ? drv : ~drv;
   assign busy_out = !(conv_r || prog);
   always @(posedge prog)
      loc_r = 4'h0;
   always @(posedge wr_n_in)
   begin
      if (prog)
         mem_r[loc_r] = {pins, 1'b0};
      else
         cfg_r = pins;
      if (prog)
         loc_r = loc_r + 4'h1;
   end
   always @(posedge rd_n_in)
      if (prog && !cs_n_in)
         loc_r = loc_r + 4'h1;
   always @(negedge cv_n_in)
      if (!cs_n_in && pd_n_in && !prog)
      begin
         cap = wr_n_in ? cfg_r : pins;
         conv_r = 1'b1;
         #(CONV_NS);
         res_r = {cap[5:2], 6'h2a, cap[1:0], cap[5:2]};
         conv_r = 1'b0;
      end
endmodule : adc_dev_model

// ### verif/tb.sv
// Self-checking bench for the converter host controller
`timescale 1ns/1ns
module tb
   import adc_host_pkg::*;
;
   // ***
   // Bench
   // ***
   typedef struct packed {logic [6:0] cfg; logic [15:0] res;} row_t;
   localparam row_t ROWS [4] = '{'{7'h00, 16'h0a80}, '{7'h7e, 16'hfabf},
                                 '{7'h2c, 16'h5aa5}, '{7'h52, 16'haa9a}};
   logic        core_clk_in, rst_n_in, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
   logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic        s_axi_rvalid, s_axi_rready, chip_select_n_out, write_n_out, read_n_out;
   logic        convert_trigger_n_out, power_down_n_out, mode_pin_zero_out;
   logic        mode_pin_one_out, pair_select_out, gain_select_out, polarity_select_out;
   logic        pair_flag_in, busy_in;
   logic [7:0]  s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd_d;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp, rd_r;
   logic [2:0]  channel_select_out, channel_echo_in;
   logic [11:0] result_line_in;
   int          n_errors = 0;
   int          tests_run = 0;
   adc_host_ctrl dut (.core_clk_in, .rst_n_in, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .chip_select_n_out, .write_n_out,
      .read_n_out, .convert_trigger_n_out, .power_down_n_out, .mode_pin_zero_out,
      .mode_pin_one_out, .channel_select_out, .pair_select_out, .gain_select_out,
      .polarity_select_out, .result_line_in, .channel_echo_in, .pair_flag_in, .busy_in);
   adc_dev_model dev (.cs_n_in(chip_select_n_out), .wr_n_in(write_n_out),
      .rd_n_in(read_n_out), .cv_n_in(convert_trigger_n_out), .pd_n_in(power_down_n_out),
      .mode_zero_in(mode_pin_zero_out), .mode_one_in(mode_pin_one_out),
      .ch_in(channel_select_out),
      .pair_in(pair_select_out), .gain_in(gain_select_out), .pol_in(polarity_select_out),
      .result_line_out(result_line_in), .channel_echo_out(channel_echo_in),
      .pair_flag_out(pair_flag_in), .busy_out(busy_in));
   task automatic conclude;
      if (n_errors == 0 && tests_run > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : conclude
   task automatic hang;
      n_errors++;
      conclude();
   endtask : hang
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      tests_run++;
      if (g !== e)
      begin
         n_errors++;
         $display("ERROR %0t got %h exp %h", $time, g, e);
      end
   endtask : chk
   // Both channels offered together; each valid drops at its own handshake
   task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
      int n;
      @(posedge core_clk_in);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (n = 0; n < 99 && !s_axi_bvalid; n++)
      begin
         @(posedge core_clk_in);
         if (s_axi_awready)
            s_axi_awvalid <= 1'b0;
         if (s_axi_wready)
            s_axi_wvalid <= 1'b0;
      end
      if (n > 98)
         hang();
      s_axi_bready <= 1'b0;
      chk(32'(s_axi_bresp), 32'(e));
   endtask : axw
   task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
      @(posedge core_clk_in);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (n = 0; n < 99 && !s_axi_rvalid; n++)
      begin
         @(posedge core_clk_in);
         if (s_axi_arready)
            s_axi_arvalid <= 1'b0;
      end
      if (n > 98)
         hang();
      s_axi_rready <= 1'b0;
      d = s_axi_rdata;
      r = s_axi_rresp;
   endtask : axr
   task automatic wdone;
      logic [31:0] d;
      logic [1:0]  r;
      d = 32'h0;
      for (int n = 0; n < 200 && d[3] !== 1'b1; n++)
         axr(STATUS_OFS, d, r);
      if (d[3] !== 1'b1)
         hang();
   endtask : wdone
   initial
   begin
      core_clk_in = 1'b0;
      forever #10 core_clk_in = ~core_clk_in;
   end
   initial
   begin
      {rst_n_in, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      s_axi_wstrb = 4'hf;
      repeat (16) @(posedge core_clk_in);
      rst_n_in <= 1'b1;
      @(posedge core_clk_in);
      chk(32'({chip_select_n_out, write_n_out, read_n_out, convert_trigger_n_out,
         power_down_n_out, mode_pin_zero_out, mode_pin_one_out, gain_select_out}), 32'hfd);
      foreach (ROWS[k])
      begin
         axw(CONFIG_OFS, 32'(ROWS[k].cfg), AXI_OKAY);
         axw(CTRL_OFS, 32'h802, AXI_OKAY);
         wdone();
         axw(CTRL_OFS, 32'h801, AXI_OKAY);
         wdone();
         axw(CTRL_OFS, 32'h804, AXI_OKAY);
         wdone();
         axr(RESULT_OFS, rd_d, rd_r);
         chk(rd_d, 32'(ROWS[k].res));
      end
      axw(CTRL_OFS, 32'h400, AXI_OKAY);
      axr(STATUS_OFS, rd_d, rd_r);
      chk(32'({rd_d[4], rd_d[1]}), 32'h1);
      for (int k = 0; k < 3; k++)
      begin
         axw(CONFIG_OFS, 32'(ROWS[k].cfg), AXI_OKAY);
         axw(CTRL_OFS, 32'h402, AXI_OKAY);
         wdone();
      end
      // Leaving and re-entering must restart the location counter
      axw(CTRL_OFS, 32'h800, AXI_OKAY);
      axw(CTRL_OFS, 32'h400, AXI_OKAY);
      for (int k = 0; k < 3; k++)
      begin
         axw(CTRL_OFS, 32'h403, AXI_OKAY);
         wdone();
         axr(ENTRY_OFS, rd_d, rd_r);
         chk(rd_d, 32'({ROWS[k].cfg[6:1], 1'b0}));
      end
      axw(CTRL_OFS, 32'h800, AXI_OKAY);
      axr(STATUS_OFS, rd_d, rd_r);
      chk(32'(rd_d[4]), 32'h1);
      axw(CTRL_OFS, 32'h900, AXI_OKAY);
      chk(32'({power_down_n_out, chip_select_n_out}), 32'h1);
      axw(CTRL_OFS, 32'hb00, AXI_OKAY);
      chk(32'({power_down_n_out, chip_select_n_out}), 32'h0);
      axw(CTRL_OFS, 32'h800, AXI_OKAY);
      axw(8'h20, 32'h0, AXI_SLVERR);
      axr(8'h24, rd_d, rd_r);
      chk({rd_d[29:0], rd_r}, 32'h2);
      conclude();
   end
endmodule : tb
